// >>> pkg/riex_map.vh
// Constants for the reset and interrupt exception unit.
// Operation
// RULE1: Reset overrides every interrupt, pending or in progress.
// RULE2: Interrupt handling starts only after current instruction or exception completes.
// RULE3: Low initialisation pin halts all processing and enters reset state.
// RULE4: External driver holds initialisation pin low at least 18 clocks.
// RULE5: Reset handling starts after pin held low long enough, then high.
// RULE6: Reset handling initialises CPU and peripherals, sets global mask bit.
// RULE7: Program counter loaded from reset vector at 0000-0001, then fetch.
// RULE8: All interrupts masked until first program instruction has executed.
// RULE9: Accepted interrupt pushes program counter and flags word via register 7.
// RULE10: Several pending requests: highest fixed priority is serviced first.
// RULE11: Mask bit set: request flags still set, nothing accepted.
// RULE12: Each of five edge pins selects rising or falling edge independently.
// RULE13: Thirteen external sources and sixteen internal peripheral sources supported.
// RULE14: At power-up driver holds pin low until clock generator stable.
// RULE15: Polarity select 0 (default) detects falling, 1 detects rising.
// RULE16: After stacking, set mask bit, then load vector of accepted source.
`ifndef RIEX_MAP_VH
`define RIEX_MAP_VH
`define RIEX_RESET_MIN_CYC 18
`define RIEX_RESET_VEC 16'h0000
`define RIEX_IRQ0_VEC 16'h0008
`define RIEX_WKP_VEC 16'h0012
`define RIEX_INT_VEC_BASE 16'h0014
`define RIEX_POL_RESET 5'h00
`define RIEX_MASK_BIT 7
`define RIEX_N_EDGE 5
`define RIEX_N_WKP 8
`define RIEX_N_INT 16
`define RIEX_SP_REG 3'h7
`define RIEX_REG_POL 4'h0
`define RIEX_REG_MASK 4'h1
`define RIEX_REG_EFLAG 4'h2
`define RIEX_REG_WFLAG 4'h3
`define RIEX_REG_STATE 4'h4
`define RIEX_POL_RSVD 3'h3
`endif

// >>> src/riex_edge.v
// Synchroniser and edge detector for one external interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module riex_edge
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Pin and polarity
  input wire pin_i,
  input wire rise_sel_i,
  // Detected edge
  output wire edge_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Rising when selected, falling otherwise. [RULE12] [RULE15]
  assign edge_o = rise_sel_i ? (s2_r & ~s3_r) : (~s2_r & s3_r);
endmodule // riex_edge
`default_nettype wire

// >>> src/riex_unit.v
// Reset and interrupt exception sequencer.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "riex_map.vh"
module riex_unit
#(
  parameter N_EDGE = `RIEX_N_EDGE,
  parameter N_WKP = `RIEX_N_WKP,
  parameter N_INT = `RIEX_N_INT
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // External pins
  input wire external_init_pin_n_i,
  input wire [N_EDGE-1:0] edge_interrupt_pins_i,
  input wire [N_WKP-1:0] wakeup_pins_n_i,
  // Internal peripheral requests
  input wire [N_INT-1:0] int_req_i,
  // Configuration and flag clearing
  input wire [N_EDGE-1:0] edge_polarity_select_i,
  input wire [N_EDGE-1:0] edge_flag_clr_i,
  input wire [N_WKP-1:0] wkp_flag_clr_i,
  // CPU core handshake
  input wire insn_done_i,
  input wire stack_done_i,
  input wire vec_done_i,
  // Software register port
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // CPU core controls
  output wire cpu_halt_o,
  output wire periph_init_o,
  output reg stack_req_o,
  output reg [2:0] stack_reg_o,
  output reg vec_fetch_o,
  output reg [15:0] vec_addr_o,
  output reg flags_mask_o,
  output wire [N_EDGE-1:0] edge_flag_o,
  output wire [N_WKP-1:0] wkp_flag_o,
  output wire irq_o
);
  // ****************************************
  // Reset pin tracking
  // ****************************************
  localparam ST_RESET = 3'h0;
  localparam ST_RVEC = 3'h1;
  localparam ST_FIRST = 3'h2;
  localparam ST_RUN = 3'h3;
  localparam ST_STACK = 3'h4;
  localparam ST_IVEC = 3'h5;
  reg rs1_r;
  reg rs2_r;
  reg [4:0] low_cnt_r;
  reg armed_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end
    else
    begin
      rs1_r <= external_init_pin_n_i;
      rs2_r <= rs1_r;
    end
  end
  wire pin_low = ~rs2_r;
  // Low time counted so that, once the first reset sequence after rst_i has run, a short glitch cannot start another.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_cnt_r <= 5'h00;
      armed_r <= 1'b1;
    end
    else if (pin_low)
    begin
      if (low_cnt_r != 5'h1f)
        low_cnt_r <= low_cnt_r + 5'h01;
      if (low_cnt_r >= (`RIEX_RESET_MIN_CYC - 1))
        armed_r <= 1'b1; // [RULE4]
    end
    else
    begin
      low_cnt_r <= 5'h00;
      if (st_r == ST_RVEC)
        armed_r <= 1'b0;
    end
  end
  // ****************************************
  // Interrupt sources
  // ****************************************
  reg [N_EDGE-1:0] pol_r;
  wire [N_EDGE-1:0] edge_ev;
  wire [N_WKP-1:0] wkp_ev;
  genvar g;
  generate
    for (g = 0; g < N_EDGE; g = g + 1)
    begin : g_edge
      riex_edge u_edge
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(edge_interrupt_pins_i[g]),
        .rise_sel_i(pol_r[g]),
        .edge_o(edge_ev[g])
      );
    end
    for (g = 0; g < N_WKP; g = g + 1)
    begin : g_wkp
      riex_edge u_wkp
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(wakeup_pins_n_i[g]),
        .rise_sel_i(1'b0),
        .edge_o(wkp_ev[g])
      );
    end
  endgenerate
  reg [N_EDGE-1:0] eflag_r;
  reg [N_WKP-1:0] wflag_r;
  reg [N_EDGE-1:0] ack_e;
  reg ack_w;
  always @(posedge clk_i)
  begin
    if (rst_i || pin_low)
    begin
      pol_r <= `RIEX_POL_RESET; // [RULE15] [RULE6]
      eflag_r <= {N_EDGE{1'b0}};
      wflag_r <= {N_WKP{1'b0}};
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == `RIEX_REG_POL)
        pol_r <= reg_wdata_i[N_EDGE-1:0];
      // Set beats clear; flags set even while masked. [RULE11]
      eflag_r <= (eflag_r & ~edge_flag_clr_i & ~ack_e) | edge_ev;
      wflag_r <= (wflag_r & ~wkp_flag_clr_i & ~{N_WKP{ack_w}}) | wkp_ev;
    end
  end
  assign edge_flag_o = eflag_r;
  assign wkp_flag_o = wflag_r;
  // ****************************************
  // Fixed priority selection
  // ****************************************
  // Edge pins first, then wakeup group, then internal sources by index. [RULE10] [RULE13]
  reg any_req;
  reg [15:0] sel_vec;
  integer i;
  integer j;
  always @*
  begin
    any_req = 1'b0;
    sel_vec = 16'h0000;
    for (i = N_INT - 1; i >= 0; i = i - 1)
      if (int_req_i[i])
      begin
        any_req = 1'b1;
        sel_vec = `RIEX_INT_VEC_BASE + 16'h0002 * i[15:0];
      end
    if (|wflag_r)
    begin
      any_req = 1'b1;
      sel_vec = `RIEX_WKP_VEC;
    end
    for (i = N_EDGE - 1; i >= 0; i = i - 1)
      if (eflag_r[i])
      begin
        any_req = 1'b1;
        sel_vec = `RIEX_IRQ0_VEC + 16'h0002 * i[15:0];
      end
  end
  // ****************************************
  // Exception sequencer
  // ****************************************
  reg [15:0] held_vec_r;
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      ST_RESET:
        if (!pin_low && armed_r)
          st_nxt = ST_RVEC; // [RULE5]
      ST_RVEC:
        if (vec_done_i)
          st_nxt = ST_FIRST; // [RULE7]
      ST_FIRST:
        if (insn_done_i)
          st_nxt = ST_RUN; // [RULE8]
      ST_RUN:
        if (insn_done_i && any_req && !flags_mask_o)
          st_nxt = ST_STACK; // [RULE2] [RULE11]
      ST_STACK:
        if (stack_done_i)
          st_nxt = ST_IVEC; // [RULE9]
      ST_IVEC:
        if (vec_done_i)
          st_nxt = ST_RUN; // [RULE16]
      default:
        st_nxt = ST_RESET;
    endcase
    if (pin_low)
      st_nxt = ST_RESET; // [RULE1] [RULE3]
  end
  always @*
  begin
    ack_e = {N_EDGE{1'b0}};
    ack_w = 1'b0;
    if (st_r == ST_RUN && st_nxt == ST_STACK)
    begin
      if (sel_vec == `RIEX_WKP_VEC)
        ack_w = 1'b1;
      for (j = 0; j < N_EDGE; j = j + 1)
        if (sel_vec == `RIEX_IRQ0_VEC + 16'h0002 * j[15:0])
          ack_e[j] = 1'b1;
    end
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_RESET;
      flags_mask_o <= 1'b1;
      held_vec_r <= `RIEX_RESET_VEC;
      stack_req_o <= 1'b0;
      stack_reg_o <= `RIEX_SP_REG;
      vec_fetch_o <= 1'b0;
      vec_addr_o <= `RIEX_RESET_VEC;
    end
    else
    begin
      st_r <= st_nxt;
      stack_reg_o <= `RIEX_SP_REG; // [RULE9]
      if (st_nxt == ST_RESET)
        flags_mask_o <= 1'b1; // [RULE6]
      else if (st_r == ST_STACK && stack_done_i)
        flags_mask_o <= 1'b1; // [RULE16]
      else if (reg_wr_i && reg_addr_i == `RIEX_REG_MASK && st_r == ST_RUN)
        flags_mask_o <= reg_wdata_i[`RIEX_MASK_BIT];
      if (st_r == ST_RUN && st_nxt == ST_STACK)
        held_vec_r <= sel_vec;
      stack_req_o <= (st_nxt == ST_STACK);
      vec_fetch_o <= (st_nxt == ST_RVEC) || (st_nxt == ST_IVEC);
      if (st_nxt == ST_RVEC)
        vec_addr_o <= `RIEX_RESET_VEC; // [RULE7]
      else if (st_nxt == ST_IVEC)
        vec_addr_o <= held_vec_r; // [RULE16]
    end
  end
  assign cpu_halt_o = (st_r == ST_RESET); // [RULE3]
  assign periph_init_o = (st_r == ST_RESET) || (st_r == ST_RVEC); // [RULE6]
  assign irq_o = any_req && !flags_mask_o && (st_r == ST_RUN);
  // ****************************************
  // Register read port
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `RIEX_REG_POL: reg_rdata_o <= {`RIEX_POL_RSVD, pol_r};
        `RIEX_REG_MASK: reg_rdata_o <= {flags_mask_o, 7'h00};
        `RIEX_REG_EFLAG: reg_rdata_o <= {3'h0, eflag_r};
        `RIEX_REG_WFLAG: reg_rdata_o <= wflag_r;
        `RIEX_REG_STATE: reg_rdata_o <= {5'h00, st_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end
endmodule // riex_unit
`default_nettype wire

// >>> testbench/riex_cpu.sv
// Behavioural CPU core that answers the exception unit.
`timescale 1ns/1ps
`default_nettype none
module riex_cpu
(
  // Clock, reset and answer delay
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] dly_i,
  // Unit controls
  input wire logic halt_i,
  input wire logic stack_req_i,
  input wire logic vec_fetch_i,
  // Completion pulses
  output logic insn_done_o,
  output logic stack_done_o,
  output logic vec_done_o
);
  // ****
  // Core
  // ****
  logic [3:0] cnt_r;
  always @(posedge clk_i)
  begin
    insn_done_o <= 1'b0;
    stack_done_o <= 1'b0;
    vec_done_o <= 1'b0;
    cnt_r <= cnt_r + 4'h1;
    if (rst_i || halt_i)
      cnt_r <= 4'h0;
    else if (stack_req_i || vec_fetch_i)
    begin
      // One pulse per request; the unit drops it a cycle later.
      if (cnt_r >= dly_i && !stack_done_o && !vec_done_o)
      begin
        stack_done_o <= stack_req_i;
        vec_done_o <= vec_fetch_i;
        cnt_r <= 4'h0;
      end
    end
    else if (cnt_r >= 4'h3)
    begin
      insn_done_o <= 1'b1;
      cnt_r <= 4'h0;
    end
  end
endmodule // riex_cpu
`default_nettype wire

// >>> testbench/riex_props.sv
// Checker for the exception unit outputs.
`timescale 1ns/1ps
`default_nettype none
module riex_props
(
  // Clock, reset and inputs
  input wire clk_i,
  input wire rst_i,
  input wire external_init_pin_n_i,
  input wire insn_done_i,
  input wire stack_done_i,
  // Watched outputs
  input wire cpu_halt_o,
  input wire periph_init_o,
  input wire stack_req_o,
  input wire [2:0] stack_reg_o,
  input wire vec_fetch_o,
  input wire flags_mask_o,
  input wire irq_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pin_halt_a: assert property ($fell(external_init_pin_n_i) |-> ##[1:4] cpu_halt_o)
    else $error("halt late");
  reset_wins_a: assert property (cpu_halt_o ##1 cpu_halt_o |-> !stack_req_o && !irq_o)
    else $error("stacking in reset");
  accept_a: assert property (irq_o && insn_done_i |=> stack_req_o)
    else $error("no accept");
  wait_insn_a: assert property ($rose(stack_req_o) |-> $past(insn_done_i))
    else $error("early accept");
  sp_reg_a: assert property (stack_req_o |-> stack_reg_o == 3'h7)
    else $error("bad stack reg");
  stack_hold_a: assert property (disable iff (rst_i || !external_init_pin_n_i)
    stack_req_o && !stack_done_i |=> stack_req_o)
    else $error("stack dropped");
  mask_set_a: assert property ($rose(vec_fetch_o) |-> flags_mask_o)
    else $error("mask clear");
  masked_a: assert property (flags_mask_o |-> !irq_o)
    else $error("irq while masked");
  halt_init_a: assert property (cpu_halt_o |-> periph_init_o)
    else $error("no init");
  first_insn_a: assert property ($fell(periph_init_o) |-> !stack_req_o ##1 !stack_req_o)
    else $error("irq before first insn");
  cover property (stack_req_o && stack_done_i);
  cover property ($fell(cpu_halt_o));
  cover property (irq_o && insn_done_i);
endmodule // riex_props
bind riex_unit riex_props chk_u (.clk_i, .rst_i, .external_init_pin_n_i, .insn_done_i, .stack_done_i,
  .cpu_halt_o, .periph_init_o, .stack_req_o, .stack_reg_o, .vec_fetch_o, .flags_mask_o, .irq_o);
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the exception unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i, rst_i, pin_n, ins, std, vd, wr, rd, halt, pinit, sreq, vf, mask, irq;
  logic [4:0] edg, eclr, ef, pv;
  logic [7:0] wkn, wclr, wd, rdat, wf, d, k;
  logic [15:0] ireq, va;
  logic [3:0] ad, dly, x;
  logic [2:0] sr;
  int err_count, num_checks, cyc;
  // Rows: kind in the upper nibble, index in the lower, and the vector expected.
  logic [7:0] r_src [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h13, 8'h20, 8'h2f};
  logic [15:0] r_vec [8] = '{16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0032};
  riex_unit dut_u (.clk_i, .rst_i, .external_init_pin_n_i(pin_n), .edge_interrupt_pins_i(edg),
    .wakeup_pins_n_i(wkn), .int_req_i(ireq), .edge_polarity_select_i(5'h00), .edge_flag_clr_i(eclr),
    .wkp_flag_clr_i(wclr), .insn_done_i(ins), .stack_done_i(std), .vec_done_i(vd), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .cpu_halt_o(halt),
    .periph_init_o(pinit), .stack_req_o(sreq), .stack_reg_o(sr), .vec_fetch_o(vf), .vec_addr_o(va),
    .flags_mask_o(mask), .edge_flag_o(ef), .wkp_flag_o(wf), .irq_o(irq));
  riex_cpu cpu_u (.clk_i, .rst_i, .dly_i(dly), .halt_i(halt), .stack_req_i(sreq), .vec_fetch_i(vf),
    .insn_done_o(ins), .stack_done_o(std), .vec_done_o(vd));
  // ****
  // Tasks
  // ****
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i); ad <= a; wd <= v; wr <= 1'b1;
    @(posedge clk_i); wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clk_i); ad <= a; rd <= 1'b1;
    @(posedge clk_i); rd <= 1'b0;
    #1 d = rdat;
  endtask
  task wvec(input logic [15:0] e);
    while (vf !== 1'b1) @(posedge clk_i) #1;
    chk("vector", e, va);
    while (vf === 1'b1) @(posedge clk_i);
  endtask
  task clr_flags;
    @(posedge clk_i); eclr <= 5'h1f; wclr <= 8'hff;
    @(posedge clk_i); eclr <= 5'h00; wclr <= 8'h00;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    rst_i = 1; pin_n = 0; edg = 5'h1f; wkn = 8'hff; ireq = 0; eclr = 0; wclr = 0;
    wr = 0; rd = 0; ad = 0; wd = 0; dly = 4'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    pin_n <= 1'b1;
    #1 chk("power-up halt", 1, halt);
    wvec(16'h0000);
    chk("mask", 1, mask);
    rreg(4'h0); chk("polarity", 8'h60, d);
    rreg(4'h9); chk("unmapped", 0, d);
    for (int i = 0; i < 8; i++)
    begin
      k = r_src[i]; x = k[3:0];
      pv = x[0] ? 5'h00 : (5'h01 << x);
      if (k[5:4] == 0) begin wreg(4'h0, {3'h0, pv}); edg[x] <= x[0]; end
      repeat (4) @(posedge clk_i);
      clr_flags();
      if (k[5:4] == 0) edg[x] <= ~x[0];
      else if (k[5:4] == 1) wkn[x] <= 1'b0;
      else ireq[x] <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1 chk("irq", 0, irq);
      if (k[5:4] == 0) chk("edge flag", 1, ef[x]);
      if (k[5:4] == 1) chk("wake flag", 1, wf[x]);
      wreg(4'h1, 8'h00);
      #1 chk("irq", 1, irq);
      wvec(r_vec[i]);
      ireq <= 0; wkn <= 8'hff;
    end
    wreg(4'h0, 8'h00); edg <= 5'h1f;
    repeat (4) @(posedge clk_i);
    clr_flags();
    edg[2] <= 1'b0; wkn[0] <= 1'b0; ireq[0] <= 1'b1;
    repeat (5) @(posedge clk_i);
    wreg(4'h1, 8'h00); wvec(16'h000c);
    wreg(4'h1, 8'h00); wvec(16'h0012);
    wreg(4'h1, 8'h00); wvec(16'h0014);
    dly <= 4'h8; wkn <= 8'hff;
    wreg(4'h1, 8'h00);
    while (sreq !== 1'b1) @(posedge clk_i);
    pin_n <= 1'b0;
    repeat (18) @(posedge clk_i) #1 chk("early fetch", 0, vf);
    chk("halt", 1, halt);
    chk("stack", 0, sreq);
    ireq <= 0;
    @(posedge clk_i); pin_n <= 1'b1;
    wvec(16'h0000);
    chk("mask", 1, mask);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
